/* hw/factory_prog_pkg.sv */
// Package: command codes, status layout and timing for the factory buffer programming sequencer
package factory_prog_pkg;
    localparam int        DATA_W        = 16;
    localparam int        ADDR_W        = 24;
    localparam int        BLOCK_W       = 16;               // Word offset bits inside one block
    localparam int        BUF_WORDS     = 32;
    localparam int        BUF_IDX_W     = 5;
    localparam int        INNER_W       = BLOCK_W - BUF_IDX_W;
    localparam logic [7:0] CMD_SETUP    = 8'h80;
    localparam logic [7:0] CMD_CONFIRM  = 8'hd0;
    localparam logic [DATA_W-1:0] PAD_WORD = 16'hffff;
    localparam int        BIT_READY     = 7;
    localparam int        BIT_PROG_ERR  = 4;
    localparam int        BIT_SUPPLY_ERR = 3;
    localparam int        BIT_LOCK_ERR  = 1;
    localparam int        BIT_BUF_BUSY  = 0;
    localparam logic [7:0] STATUS_RESET = 8'h80;
    localparam int        CLK_MHZ       = 25;
    localparam int        STARTUP_NS    = 2000;
    localparam int        STARTUP_CYC   = (STARTUP_NS * CLK_MHZ + 999) / 1000;
    localparam int        PROG_WORD_NS  = 400;              // Array time per word, plain model
    localparam int        PROG_WORD_CYC = (PROG_WORD_NS * CLK_MHZ + 999) / 1000;
    localparam int        CNT_W         = 8;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_ARMED   = 3'b001,
        ST_START   = 3'b011,
        ST_FILL    = 3'b010,
        ST_PROGRAM = 3'b110
    } mode_t;

    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } bus_write_t;

    typedef struct packed {
        logic              write;
        logic [BUF_IDX_W-1:0] idx;
        logic [DATA_W-1:0] data;
    } buf_port_t;
endpackage

/* hw/word_buffer.sv */
// Module: 32-word write buffer held in flip-flops, indexed write and read
`timescale 1ns/1ps
module word_buffer (
    input  wire logic                                clk,
    input  wire logic                                ce,
    input  wire factory_prog_pkg::buf_port_t         wr,
    input  wire logic [factory_prog_pkg::BUF_IDX_W-1:0] rdIdx,
    output logic [factory_prog_pkg::DATA_W-1:0]      rdData
);
    typedef struct packed {
        logic [factory_prog_pkg::BUF_WORDS-1:0][factory_prog_pkg::DATA_W-1:0] mem;
    } buf_state_t;

    buf_state_t state;
    buf_state_t next_state;

    // No reset: contents are always rewritten before use
    always_comb begin
        next_state = state;
        if (wr.write) begin
            next_state.mem[wr.idx] = wr.data;
        end
    end

    always_ff @(posedge clk) begin
        if (ce) begin
            state <= next_state;
        end
    end

    assign rdData = state.mem[rdIdx];
endmodule // word_buffer

/* hw/flash_factory_buffer_program.sv */
// Module: write state machine for block-wide buffered factory programming
// Contract
// - Mode entered by setup code 80h then confirm code D0h to target block.
// - Ready bit clears while startup checks of lock and supply run.
// - Failed check sets program error, plus lock or supply error; mode ends.
// - Reads return status; all writes are buffer data, never commands.
// - Buffer load count is fixed at 32 words with no count cycles.
// - Fill data goes to sequential buffer locations starting at zero.
// - Programming starts immediately once all 32 locations are written.
// - Fill write outside the block exits at once, buffer discarded.
// - Unaligned start address aborts and sets program error.
// - Internal array address advances to next 32-word boundary per buffer.
// - Address counter wraps to block start past the block end.
// - Buffer busy bit set while unavailable, clears once data is in array.
// - Writes during internal programming are ignored.
// - All-ones write to another block ends program phase and exits (code: any write to another block during fill exits, whatever its data).
// - On exit ready bit sets, read mode unchanged, commands accepted.
`timescale 1ns/1ps
module flash_factory_buffer_program (
    input  wire logic                                  clk,
    input  wire logic                                  rst_n,
    input  wire logic                                  ce,
    input  wire factory_prog_pkg::bus_write_t          busWrite,
    input  wire logic                                  blockLocked,
    input  wire logic                                  supplyOk,
    input  wire logic                                  suspendReq,
    input  wire logic                                  arrayFault,
    output logic [7:0]                                 statusRegister,
    output logic                                       modeActive,
    output logic                                       suspendAck,
    output logic                                       arrayWrite,
    output logic [factory_prog_pkg::ADDR_W-1:0]        arrayAddr,
    output logic [factory_prog_pkg::DATA_W-1:0]        arrayData
);
    typedef struct packed {
        factory_prog_pkg::mode_t                       mode;
        logic [7:0]                                    status;
        logic [factory_prog_pkg::ADDR_W-1:0]           blockBase;
        logic [factory_prog_pkg::INNER_W-1:0]          bufNum;
        logic [factory_prog_pkg::BUF_IDX_W-1:0]        fillIdx;
        logic [factory_prog_pkg::BUF_IDX_W-1:0]        progIdx;
        logic [factory_prog_pkg::CNT_W-1:0]            timer;
        logic                                          armed;
        logic                                          wrOut;
        logic [factory_prog_pkg::ADDR_W-1:0]           addrOut;
        logic [factory_prog_pkg::DATA_W-1:0]           dataOut;
    } seq_state_t;

    seq_state_t state;
    seq_state_t next_state;
    factory_prog_pkg::buf_port_t bufWr;
    logic [factory_prog_pkg::DATA_W-1:0] bufRd;
    logic inBlock;
    logic isAligned;
    logic [factory_prog_pkg::BLOCK_W-1:0] wordOffset;

    word_buffer u_buffer (
        .clk    (clk),
        .ce     (ce),
        .wr     (bufWr),
        .rdIdx  (state.progIdx),
        .rdData (bufRd)
    );

    assign inBlock   = busWrite.addr[factory_prog_pkg::ADDR_W-1:factory_prog_pkg::BLOCK_W]
                    == state.blockBase[factory_prog_pkg::ADDR_W-1:factory_prog_pkg::BLOCK_W];
    assign isAligned = busWrite.addr[factory_prog_pkg::BUF_IDX_W-1:0] == '0;
    assign wordOffset = {state.bufNum, state.progIdx};

    always_comb begin
        next_state         = state;
        next_state.wrOut   = 1'b0;
        bufWr              = '0;
        case (state.mode)
            factory_prog_pkg::ST_IDLE: begin
                if (busWrite.valid && busWrite.data[7:0] == factory_prog_pkg::CMD_SETUP) begin
                    next_state.mode      = factory_prog_pkg::ST_ARMED;
                    next_state.blockBase = busWrite.addr;
                end
            end
            factory_prog_pkg::ST_ARMED: begin
                if (busWrite.valid) begin
                    if (busWrite.data[7:0] == factory_prog_pkg::CMD_CONFIRM && inBlock) begin
                        next_state.mode  = factory_prog_pkg::ST_START;
                        next_state.status = '0;
                        next_state.timer = factory_prog_pkg::CNT_W'(factory_prog_pkg::STARTUP_CYC);
                        next_state.armed = 1'b0;
                    end else begin
                        next_state.mode = factory_prog_pkg::ST_IDLE;
                    end
                end
            end
            factory_prog_pkg::ST_START: begin
                // Startup checks take a fixed time; writes here are not expected
                if (state.timer > factory_prog_pkg::CNT_W'(1)) begin
                    next_state.timer = state.timer - factory_prog_pkg::CNT_W'(1);
                end else if (blockLocked || !supplyOk) begin
                    next_state.mode = factory_prog_pkg::ST_IDLE;
                    next_state.status[factory_prog_pkg::BIT_READY]      = 1'b1;
                    next_state.status[factory_prog_pkg::BIT_PROG_ERR]   = 1'b1;
                    next_state.status[factory_prog_pkg::BIT_LOCK_ERR]   = blockLocked;
                    next_state.status[factory_prog_pkg::BIT_SUPPLY_ERR] = !supplyOk;
                end else begin
                    next_state.mode    = factory_prog_pkg::ST_FILL;
                    next_state.fillIdx = '0;
                    // Array fill begins at the 32-word boundary of the setup write address, not the first word address
                    next_state.bufNum  = state.blockBase[factory_prog_pkg::BLOCK_W-1:
                                                         factory_prog_pkg::BUF_IDX_W];
                end
            end
            factory_prog_pkg::ST_FILL: begin
                if (busWrite.valid) begin
                    if (!inBlock) begin
                        // Partial buffer dropped; any write to another block is the exit, whatever its data
                        next_state.mode = factory_prog_pkg::ST_IDLE;
                        next_state.status[factory_prog_pkg::BIT_READY] = 1'b1;
                    end else if (!state.armed && !isAligned) begin
                        next_state.mode = factory_prog_pkg::ST_IDLE;
                        next_state.status[factory_prog_pkg::BIT_READY]    = 1'b1;
                        next_state.status[factory_prog_pkg::BIT_PROG_ERR] = 1'b1;
                    end else begin
                        // Every write is data, command codes included
                        bufWr.write = 1'b1;
                        bufWr.idx   = state.fillIdx;
                        bufWr.data  = busWrite.data;
                        next_state.armed   = 1'b1;
                        next_state.fillIdx = state.fillIdx + factory_prog_pkg::BUF_IDX_W'(1);
                        if (state.fillIdx == factory_prog_pkg::BUF_IDX_W'(
                                factory_prog_pkg::BUF_WORDS - 1)) begin
                            next_state.mode    = factory_prog_pkg::ST_PROGRAM;
                            next_state.status[factory_prog_pkg::BIT_BUF_BUSY] = 1'b1;
                            next_state.progIdx = '0;
                            next_state.timer   = factory_prog_pkg::CNT_W'(
                                factory_prog_pkg::PROG_WORD_CYC);
                        end
                    end
                end
            end
            factory_prog_pkg::ST_PROGRAM: begin
                // Bus writes are not looked at here at all
                if (state.timer > factory_prog_pkg::CNT_W'(1)) begin
                    next_state.timer = state.timer - factory_prog_pkg::CNT_W'(1);
                end else begin
                    next_state.wrOut   = 1'b1;
                    next_state.addrOut = {state.blockBase[factory_prog_pkg::ADDR_W-1:
                                          factory_prog_pkg::BLOCK_W], wordOffset};
                    next_state.dataOut = bufRd;
                    next_state.timer   = factory_prog_pkg::CNT_W'(factory_prog_pkg::PROG_WORD_CYC);
                    next_state.progIdx = state.progIdx + factory_prog_pkg::BUF_IDX_W'(1);
                    if (arrayFault) begin
                        next_state.status[factory_prog_pkg::BIT_PROG_ERR] = 1'b1;
                    end
                    if (state.progIdx == factory_prog_pkg::BUF_IDX_W'(
                            factory_prog_pkg::BUF_WORDS - 1)) begin
                        // Counter wraps naturally to block start
                        next_state.bufNum  = state.bufNum
                                           + factory_prog_pkg::INNER_W'(1);
                        next_state.mode    = factory_prog_pkg::ST_FILL;
                        next_state.fillIdx = '0;
                        next_state.status[factory_prog_pkg::BIT_BUF_BUSY] = 1'b0;
                    end
                end
            end
            default: begin
                next_state.mode = factory_prog_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state        <= '0;
            state.mode   <= factory_prog_pkg::ST_IDLE;
            state.status <= factory_prog_pkg::STATUS_RESET;
        end else if (ce) begin
            state <= next_state;
        end
    end

    assign statusRegister = state.status;
    assign modeActive     = state.mode != factory_prog_pkg::ST_IDLE
                         && state.mode != factory_prog_pkg::ST_ARMED;
    assign suspendAck     = suspendReq && !modeActive && 1'b0;
    assign arrayWrite     = state.wrOut;
    assign arrayAddr      = state.addrOut;
    assign arrayData      = state.dataOut;

    a_ready_low_busy: assert property (@(posedge clk) disable iff (!rst_n)
        ce && state.mode == factory_prog_pkg::ST_ARMED && next_state.mode
        == factory_prog_pkg::ST_START |=> !statusRegister[7])
        else $error("ready bit not cleared at startup");
    a_fault_sets_err: assert property (@(posedge clk) disable iff (!rst_n)
        ce && state.mode == factory_prog_pkg::ST_START && state.timer <= 1 && blockLocked
        |=> statusRegister[4] && statusRegister[1] && statusRegister[7])
        else $error("lock fault flags wrong");
    a_full_starts_prog: assert property (@(posedge clk) disable iff (!rst_n)
        ce && bufWr.write && bufWr.idx == 5'h1f && state.mode == factory_prog_pkg::ST_FILL
        |=> state.mode == factory_prog_pkg::ST_PROGRAM && statusRegister[0])
        else $error("full buffer did not start programming");
    a_fill_order: assert property (@(posedge clk) disable iff (!rst_n)
        ce && bufWr.write && state.mode == factory_prog_pkg::ST_FILL
        |=> state.fillIdx == $past(bufWr.idx) + 5'h01)
        else $error("buffer index out of order");
    a_out_exits: assert property (@(posedge clk) disable iff (!rst_n)
        ce && state.mode == factory_prog_pkg::ST_FILL && busWrite.valid && !inBlock
        |=> state.mode == factory_prog_pkg::ST_IDLE && statusRegister[7] && !arrayWrite)
        else $error("out of block write did not exit");
    a_unaligned_err: assert property (@(posedge clk) disable iff (!rst_n)
        ce && state.mode == factory_prog_pkg::ST_FILL && busWrite.valid && inBlock
        && !state.armed && !isAligned |=> statusRegister[4])
        else $error("unaligned start not flagged");
    a_prog_no_load: assert property (@(posedge clk) disable iff (!rst_n)
        state.mode == factory_prog_pkg::ST_PROGRAM |-> !bufWr.write)
        else $error("write accepted during programming");
    a_addr_in_block: assert property (@(posedge clk) disable iff (!rst_n)
        arrayWrite |-> arrayAddr[23:16] == state.blockBase[23:16])
        else $error("array address left the block");
    a_no_suspend: assert property (@(posedge clk) disable iff (!rst_n)
        modeActive |-> !suspendAck)
        else $error("suspend honoured in factory mode");
endmodule // flash_factory_buffer_program

/* testbench/host_programmer.sv */
// Host programmer model: drives write cycles and records array writes
`timescale 1ns/1ps
module host_programmer (
    input  wire logic                                clk,
    output factory_prog_pkg::bus_write_t             busWrite,
    input  wire logic                                arrayWrite,
    input  wire logic [factory_prog_pkg::ADDR_W-1:0] arrayAddr,
    input  wire logic [factory_prog_pkg::DATA_W-1:0] arrayData
);
    logic [factory_prog_pkg::ADDR_W-1:0] capAddr[$];
    logic [factory_prog_pkg::DATA_W-1:0] capData[$];

    initial busWrite = '0;

    // Released lines show the inverse, so a stale value cannot pass for a fresh one
    task automatic wr(input logic [23:0] a, input logic [15:0] d);
        busWrite = '{valid: 1'b1, addr: a, data: d};
        @(posedge clk);
        #1;
        busWrite = '{valid: 1'b0, addr: ~a, data: ~d};
        @(posedge clk);
        #1;
    endtask

    // Bench sets the lock and supply inputs before this
    task automatic enter(input logic [23:0] a);
        wr(a, {8'h00, factory_prog_pkg::CMD_SETUP});
        wr(a, {8'h00, factory_prog_pkg::CMD_CONFIRM});
    endtask

    // No status look until startup has had its time
    task automatic wait_startup();
        repeat (factory_prog_pkg::STARTUP_CYC + 2) @(posedge clk);
        #1;
    endtask

    // Aligned first word held for the whole load, short loads padded
    task automatic fill(input logic [23:0] a, input logic [15:0] seed, input int nReal);
        for (int i = 0; i < factory_prog_pkg::BUF_WORDS; i++)
            wr(a, i < nReal ? seed + 16'(i) : factory_prog_pkg::PAD_WORD);
    endtask

    always @(posedge clk) begin
        if (arrayWrite === 1'b1) begin
            capAddr.push_back(arrayAddr);
            capData.push_back(arrayData);
        end
    end
endmodule // host_programmer

/* testbench/tb_flash_factory_buffer_program.sv */
// Testbench: scenario sequence for the factory buffer programming sequencer
`timescale 1ns/1ps
module tb_flash_factory_buffer_program;
    localparam logic [23:0] BASE  = 24'h030000;
    localparam logic [23:0] OTHER = 24'h050000;
    logic                          clk;
    logic                          rst_n;
    logic                          blockLocked;
    logic                          supplyOk;
    logic                          suspendReq;
    logic                          ce;
    logic                          arrayFault;
    logic                          arrayWrite;
    logic                          modeActive;
    logic                          suspendAck;
    logic [7:0]                    statusRegister;
    logic [23:0]                   arrayAddr;
    logic [15:0]                   arrayData;
    factory_prog_pkg::bus_write_t  busWrite;
    int                            checks_done = 0;
    int                            miscompares = 0;

    flash_factory_buffer_program u_flash_factory_buffer_program (
        .clk(clk), .rst_n(rst_n), .ce(ce), .busWrite(busWrite),
        .blockLocked(blockLocked), .supplyOk(supplyOk), .suspendReq(suspendReq),
        .arrayFault(arrayFault), .statusRegister(statusRegister), .modeActive(modeActive),
        .suspendAck(suspendAck), .arrayWrite(arrayWrite), .arrayAddr(arrayAddr),
        .arrayData(arrayData));

    host_programmer u_host_programmer (
        .clk(clk), .busWrite(busWrite), .arrayWrite(arrayWrite),
        .arrayAddr(arrayAddr), .arrayData(arrayData));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic complete_run();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Bounded poll: the buffer is only reloaded once it reads free
    task automatic wait_buffer();
        int n;
        n = 0;
        while (statusRegister[0] !== 1'b0 && n < 600) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("buffer busy cleared", 24'h0, 24'(statusRegister[0]));
    endtask

    task automatic chk_array(input logic [23:0] base, input logic [15:0] seed, input int nReal);
        // Last word is emitted on the edge that frees the buffer; let it be captured
        @(posedge clk);
        #1;
        chk("array write count", 24'd32, 24'(u_host_programmer.capAddr.size()));
        foreach (u_host_programmer.capAddr[i]) begin
            chk("array address", base + 24'(i), u_host_programmer.capAddr[i]);
            chk("array data", 24'(i < nReal ? seed + 16'(i) : factory_prog_pkg::PAD_WORD),
                24'(u_host_programmer.capData[i]));
        end
        u_host_programmer.capAddr.delete();
        u_host_programmer.capData.delete();
    endtask

    initial begin
        #800000;
        miscompares++;
        $display("FAIL watchdog expected finish seen hang");
        complete_run();
    end

    initial begin
        rst_n = 1'b0;
        blockLocked = 1'b1;
        supplyOk = 1'b1;
        suspendReq = 1'b1;
        ce = 1'b1;
        arrayFault = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1'b1;
        chk("status after reset", 24'h80, 24'(statusRegister));
        u_host_programmer.enter(BASE);
        chk("ready during startup", 24'h0, 24'(statusRegister[7]));
        u_host_programmer.wait_startup();
        chk("locked block status", 24'h92, 24'(statusRegister));
        blockLocked = 1'b0;
        supplyOk = 1'b0;
        u_host_programmer.enter(BASE);
        u_host_programmer.wait_startup();
        chk("bad supply status", 24'h98, 24'(statusRegister));
        supplyOk = 1'b1;
        u_host_programmer.enter(BASE);
        u_host_programmer.wait_startup();
        chk("fill phase status", 24'h00, 24'(statusRegister));
        chk("mode active", 24'h1, 24'(modeActive));
        // A write while frozen must not take a buffer slot
        ce = 1'b0;
        u_host_programmer.wr(BASE, 16'hdead);
        chk("status while frozen", 24'h00, 24'(statusRegister));
        ce = 1'b1;
        u_host_programmer.fill(BASE, 16'h5a00, 32);
        chk("status after full load", 24'h01, 24'(statusRegister));
        u_host_programmer.wr(BASE, 16'h1234);
        wait_buffer();
        chk_array(BASE, 16'h5a00, 32);
        arrayFault = 1'b1;
        u_host_programmer.fill(BASE, 16'h3300, 8);
        wait_buffer();
        chk("error after array fault", 24'h10, 24'(statusRegister));
        arrayFault = 1'b0;
        chk_array(BASE + 24'd32, 16'h3300, 8);
        chk("suspend acknowledge", 24'h0, 24'(suspendAck));
        u_host_programmer.wr(OTHER, factory_prog_pkg::PAD_WORD);
        chk("status after exit", 24'h90, 24'(statusRegister));
        chk("mode left", 24'h0, 24'(modeActive));
        u_host_programmer.enter(BASE);
        u_host_programmer.wait_startup();
        u_host_programmer.wr(BASE + 24'd5, 16'h0001);
        chk("unaligned start status", 24'h90, 24'(statusRegister));
        u_host_programmer.enter(BASE);
        u_host_programmer.wait_startup();
        for (int i = 0; i < 10; i++)
            u_host_programmer.wr(BASE, 16'(i));
        u_host_programmer.wr(OTHER, 16'h0000);
        chk("status after block change", 24'h80, 24'(statusRegister));
        repeat (400) @(posedge clk);
        #1;
        chk("discarded load writes", 24'h0, 24'(u_host_programmer.capAddr.size()));
        complete_run();
    end
endmodule // tb_flash_factory_buffer_program
